// >>> shared/pct_pkg.sv
// Purpose: constants and types for the palette control and test registers
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: offsets and channel codes shared by design and bench
package pct_pkg;

  localparam logic [31:0] PCT_OFF_GCTL = 32'h0000_0000;
  localparam logic [31:0] PCT_OFF_TEST = 32'h0000_0004;
  localparam int PCT_ADDR_W = 4;

  localparam logic [7:0] PCT_GCTL_RESET = 8'h03;
  localparam int PCT_GCTL_LSYNC_POL = 0;
  localparam int PCT_GCTL_FSYNC_POL = 1;
  localparam int PCT_GCTL_SPLIT = 2;
  localparam int PCT_GCTL_NIBBLE = 3;
  localparam int PCT_GCTL_PEDESTAL = 4;
  localparam int PCT_GCTL_SOG = 5;
  localparam int PCT_GCTL_BIG_END = 6;
  localparam int PCT_GCTL_EXT_SEL = 7;

  // arbitrary neutral value
  localparam logic [7:0] PCT_ID_CODE = 8'h5A;

  localparam logic [1:0] PCT_RESP_OKAY = 2'b00;
  localparam logic [1:0] PCT_RESP_SLVERR = 2'b10;

  localparam int PCT_SYNC_W = 27;

  typedef enum logic [2:0] {
    PCT_CH_RED = 3'b000,
    PCT_CH_GREEN = 3'b001,
    PCT_CH_BLUE = 3'b010,
    PCT_CH_ID = 3'b011,
    PCT_CH_ACC_RED = 3'b100,
    PCT_CH_ACC_GREEN = 3'b101,
    PCT_CH_ACC_BLUE = 3'b110,
    PCT_CH_ANALOG = 3'b111
  } pct_chan_t;

  typedef struct packed {
    logic ext_sel;
    logic big_end;
    logic sog;
    logic pedestal;
    logic nibble;
    logic split;
    logic fsync_pol;
    logic lsync_pol;
  } pct_gctl_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } pct_pixel_t;

endpackage

// >>> src/pct_regs.sv
// Purpose: general control and test channel registers of a video palette
// Assumes: host on AXI4-Lite, pins synchronised here, one clock aclk
// Notes:
// Operation
// - mux select low at reset, passthrough
// - bit 7 only drives mux select level
// - bit 4 selects 0 or 7.5 IRE pedestal
// - bit 5 enables sync on green output
// - bit 6 selects little or big endian
// - bits 0..3 sync polarity, split, nibble
// - polarity bits reset 1, normal modes only
// - split and nibble exclusive, flag ignored
// - test write stores control, read data
// - three bit control selects eight channels
// - colour channel reads dac input component
// - each colour read advances, blue wraps red
// - id channel returns fixed code always
// - id read advances, never returns unless rewritten
// - flow, analog, integrity tests via control
`timescale 1ns/1ps
`default_nettype none
module pct_regs
  import pct_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic passthru_mode,
  input wire logic line_sync_in,
  input wire logic frame_sync_in,
  input wire logic split_nibble_flag,
  input wire pct_pixel_t dac_in,
  output logic ext_select_out,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic split_transfer_enable,
  output logic nibble_mode_enable,
  output logic split_nibble_qual,
  output logic pedestal_7p5,
  output logic green_sync_enable,
  output logic big_endian
);

  function automatic pct_chan_t pct_next_chan(input pct_chan_t c);
    case (c)
      PCT_CH_RED: pct_next_chan = PCT_CH_GREEN;
      PCT_CH_GREEN: pct_next_chan = PCT_CH_BLUE;
      PCT_CH_BLUE: pct_next_chan = PCT_CH_RED;
      PCT_CH_ID: pct_next_chan = PCT_CH_RED;
      default: pct_next_chan = c;
    endcase
  endfunction

  // a set upper address bit pushes the index to an unmapped slot
  function automatic logic [PCT_ADDR_W-1:0] pct_addr_idx(input logic [31:0] a);
    if (a[31:PCT_ADDR_W] == '0) begin
      pct_addr_idx = a[PCT_ADDR_W-1:0];
    end else begin
      pct_addr_idx = '1;
    end
  endfunction

  function automatic logic pct_is_gctl(input logic [PCT_ADDR_W-1:0] idx);
    pct_is_gctl = (idx == PCT_OFF_GCTL[PCT_ADDR_W-1:0]);
  endfunction

  function automatic logic pct_is_test(input logic [PCT_ADDR_W-1:0] idx);
    pct_is_test = (idx == PCT_OFF_TEST[PCT_ADDR_W-1:0]);
  endfunction

  // unmapped slots answer slverr and change nothing
  function automatic logic [1:0] pct_resp(input logic [PCT_ADDR_W-1:0] idx);
    if (pct_is_gctl(idx) || pct_is_test(idx)) begin
      pct_resp = PCT_RESP_OKAY;
    end else begin
      pct_resp = PCT_RESP_SLVERR;
    end
  endfunction

  // passthrough syncs already carry monitor polarity
  function automatic logic pct_sync_level(input logic lvl, input logic pol, input logic pass);
    if (pass) begin
      pct_sync_level = lvl;
    end else begin
      pct_sync_level = lvl ^ pol;
    end
  endfunction

  // a lone disagreeing stage holds the old value, so one-cycle glitches die here
  function automatic logic [PCT_SYNC_W-1:0] pct_agree(input logic [PCT_SYNC_W-1:0] a,
                                                       input logic [PCT_SYNC_W-1:0] b,
                                                       input logic [PCT_SYNC_W-1:0] held);
    pct_agree = (a & b) | (held & (a | b));
  endfunction

  pct_gctl_t gctl_q;
  pct_chan_t chan_q;
  logic [3:0] analog_sel_q;
  logic [PCT_ADDR_W-1:0] awaddr_q;
  logic aw_held_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic w_held_q;
  logic [PCT_SYNC_W-1:0] s1_q;
  logic [PCT_SYNC_W-1:0] s2_q;
  logic [PCT_SYNC_W-1:0] s3_q;
  logic [PCT_SYNC_W-1:0] pins_q;
  pct_pixel_t dac_s;
  logic lsync_s;
  logic fsync_s;
  logic flag_s;
  logic do_write;
  logic wr_gctl;
  logic wr_test;
  logic do_read;
  logic [PCT_ADDR_W-1:0] rd_idx;
  logic rd_test;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;

  // three-stage pin sync; a bit changes once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pins_q <= '0;
    end else begin
      s1_q <= {split_nibble_flag, line_sync_in, frame_sync_in, dac_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pins_q <= pct_agree(s2_q, s3_q, pins_q);
    end
  end

  assign dac_s = pins_q[23:0];
  assign fsync_s = pins_q[24];
  assign lsync_s = pins_q[25];
  assign flag_s = pins_q[26];

  // write channel: address and data taken in either order
  assign do_write = aw_held_q && w_held_q && !s_bvalid;
  assign wr_gctl = do_write && wstrb0_q && pct_is_gctl(awaddr_q);
  assign wr_test = do_write && wstrb0_q && pct_is_test(awaddr_q);

  // address slot; ready stays low while an address waits for its data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
      s_awready <= 1'b0;
    end else begin
      s_awready <= !aw_held_q && !s_awready;
      if (s_awvalid && s_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= pct_addr_idx(s_awaddr);
        s_awready <= 1'b0;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  // data slot; only byte lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      s_wready <= !w_held_q && !s_wready;
      if (s_wvalid && s_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_wdata[7:0];
        wstrb0_q <= s_wstrb[0];
        s_wready <= 1'b0;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= PCT_RESP_OKAY;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp <= pct_resp(awaddr_q);
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // general control, plain read-back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gctl_q <= PCT_GCTL_RESET;
    end else if (wr_gctl) begin
      gctl_q <= wdata_q;
    end
  end

  // read channel
  assign do_read = s_arvalid && s_arready;
  assign rd_idx = pct_addr_idx(s_araddr);
  assign rd_test = do_read && pct_is_test(rd_idx);

  // read word for the address on the bus; bits 31:8 stay zero
  always_comb begin
    rdata_d = '0;
    rresp_d = pct_resp(rd_idx);
    if (pct_is_gctl(rd_idx)) begin
      rdata_d[7:0] = gctl_q;
    end else if (pct_is_test(rd_idx)) begin
      // host must hold dac data steady over the read
      case (chan_q)
        PCT_CH_RED: rdata_d[7:0] = dac_s.red;
        PCT_CH_GREEN: rdata_d[7:0] = dac_s.green;
        PCT_CH_BLUE: rdata_d[7:0] = dac_s.blue;
        PCT_CH_ID: rdata_d[7:0] = PCT_ID_CODE;
        // comparator result bit is not built and reads 0
        PCT_CH_ANALOG: rdata_d[7:0] = {analog_sel_q, 1'b0, chan_q};
        default: rdata_d[7:0] = {5'h00, chan_q};
      endcase
    end
  end

  // test control word; a write in the same cycle as a read wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_q <= PCT_CH_RED;
      analog_sel_q <= '0;
    end else if (wr_test) begin
      chan_q <= pct_chan_t'(wdata_q[2:0]);
      analog_sel_q <= wdata_q[7:4];
    end else if (rd_test) begin
      chan_q <= pct_next_chan(chan_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= PCT_RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !s_arready && !s_arvalid ? 1'b1 : (!s_rvalid && !do_read);
      if (do_read) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rresp <= rresp_d;
        s_rdata <= rdata_d;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // video side controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_select_out <= 1'b0;
      line_sync_out <= 1'b1;
      frame_sync_out <= 1'b1;
      split_transfer_enable <= 1'b0;
      nibble_mode_enable <= 1'b0;
      split_nibble_qual <= 1'b0;
      pedestal_7p5 <= 1'b0;
      green_sync_enable <= 1'b0;
      big_endian <= 1'b0;
    end else begin
      ext_select_out <= !passthru_mode && gctl_q.ext_sel;
      line_sync_out <= pct_sync_level(lsync_s, gctl_q.lsync_pol, passthru_mode);
      frame_sync_out <= pct_sync_level(fsync_s, gctl_q.fsync_pol, passthru_mode);
      // both set is illegal; treated as both off to stay benign
      split_transfer_enable <= gctl_q.split && !gctl_q.nibble;
      nibble_mode_enable <= gctl_q.nibble && !gctl_q.split;
      split_nibble_qual <= flag_s && (gctl_q.split ^ gctl_q.nibble);
      pedestal_7p5 <= gctl_q.pedestal;
      green_sync_enable <= gctl_q.sog;
      big_endian <= gctl_q.big_end;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/pct_vsrc.sv
// Purpose: pixel and sync source facing the pin side
// Assumes: bench sets the requested levels
// Notes: levels only move when the bench asks
`timescale 1ns/1ps
`default_nettype none
module pct_vsrc
  import pct_pkg::*;
(
  input wire pct_pixel_t pix_req,
  input wire logic [1:0] sync_req,
  input wire logic flag_req,
  output var pct_pixel_t dac_in,
  output logic line_sync_in,
  output logic frame_sync_in,
  output logic split_nibble_flag
);
  // held steady across test reads
  assign dac_in = pix_req;
  assign {frame_sync_in, line_sync_in} = sync_req;
  assign split_nibble_flag = flag_req;
endmodule
`default_nettype wire

// >>> testbench/pct_regs_chk.sv
// Purpose: port checks for pct_regs
// Assumes: one clock, sync low reset
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module pct_regs_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_bvalid,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic passthru_mode,
  input wire logic ext_select_out,
  input wire logic line_sync_out,
  input wire logic frame_sync_out,
  input wire logic split_transfer_enable,
  input wire logic nibble_mode_enable,
  input wire logic split_nibble_qual
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_aw_taken; s_awvalid && s_awready; endsequence
  sequence s_ar_taken; s_arvalid && s_arready; endsequence
  a_ext_sel_pass: assert property (passthru_mode |=> !ext_select_out)
    else $error("ext select high in passthrough");
  a_ext_sel_rst: assert property (disable iff (1'b0) !aresetn |=> !ext_select_out)
    else $error("ext select high after reset");
  a_sync_rst_high: assert property (disable iff (1'b0) !aresetn |=> line_sync_out && frame_sync_out)
    else $error("sync outputs not high after reset");
  a_mode_excl: assert property (!(split_transfer_enable && nibble_mode_enable))
    else $error("split and nibble both on");
  a_flag_ignored: assert property (!split_transfer_enable && !nibble_mode_enable |-> !split_nibble_qual)
    else $error("flag passed while both modes off");
  a_read_answer: assert property (s_ar_taken |=> s_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped before taken");
  a_write_answer: assert property (s_aw_taken |-> ##[1:8] s_bvalid)
    else $error("write response missing");
  a_rdata_upper: assert property (s_rvalid |-> s_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
endmodule
`default_nettype wire

// >>> testbench/palette_control_and_test_regs_test.sv
// Purpose: self-checking bench for pct_regs
// Assumes: AXI4-Lite master tasks, seeded xorshift
// Notes: expectations from bench functions only
`timescale 1ns/1ps
`default_nettype none
module palette_control_and_test_regs_test;
  import pct_pkg::*;
  logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, s_rdata, seed = 32'h0001_2773;
  logic [3:0] s_wstrb = 4'hF;
  logic [1:0] s_bresp, s_rresp, sync_req = 2'b11;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_select_out, line_sync_out, frame_sync_out;
  logic split_transfer_enable, nibble_mode_enable, split_nibble_qual, pedestal_7p5, green_sync_enable, big_endian;
  logic passthru_mode = 0, flag_req = 0, line_sync_in, frame_sync_in, split_nibble_flag;
  pct_pixel_t dac_in, pix = '0;
  int fails = 0, n_compared = 0;
  pct_regs pct_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .passthru_mode(passthru_mode), .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in),
    .split_nibble_flag(split_nibble_flag), .dac_in(dac_in), .ext_select_out(ext_select_out),
    .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out), .split_transfer_enable(split_transfer_enable),
    .nibble_mode_enable(nibble_mode_enable), .split_nibble_qual(split_nibble_qual), .pedestal_7p5(pedestal_7p5),
    .green_sync_enable(green_sync_enable), .big_endian(big_endian));
  pct_vsrc pct_vsrc_inst (.pix_req(pix), .sync_req(sync_req), .flag_req(flag_req), .dac_in(dac_in),
    .line_sync_in(line_sync_in), .frame_sync_in(frame_sync_in), .split_nibble_flag(split_nibble_flag));
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // colour channels read the held pixel, id the fixed code, the rest echo the code
  function automatic logic [31:0] chan_val(input logic [2:0] c);
    case (c)
      3'h0: return {24'h0, pix.red};
      3'h1: return {24'h0, pix.green};
      3'h2: return {24'h0, pix.blue};
      3'h3: return {24'h0, PCT_ID_CODE};
      default: return {29'h0, c};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= {24'h0, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready && s_awvalid) s_awvalid <= 1'b0;
      if (s_wready && s_wvalid) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready && s_arvalid) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    logic [31:0] d;
    logic [7:0] g;
    logic [1:0] r;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(PCT_OFF_GCTL, d, r);
    chk(d, {24'h0, PCT_GCTL_RESET});
    repeat (12) begin
      d = xs();
      g = d[7:0];
      if (g[3:2] == 2'b11) g[3] = 1'b0; // host keeps the two modes exclusive
      passthru_mode <= d[8];
      sync_req <= d[10:9];
      flag_req <= d[11];
      axw(PCT_OFF_GCTL, g, r);
      chk(32'(r), 32'(PCT_RESP_OKAY));
      axr(PCT_OFF_GCTL, d, r);
      chk(d, {24'h0, g});
      repeat (8) @(posedge aclk);
      chk(32'(ext_select_out), 32'(g[7] & ~passthru_mode));
      chk(32'({big_endian, green_sync_enable, pedestal_7p5}), 32'(g[6:4]));
      chk(32'({nibble_mode_enable, split_transfer_enable}), 32'(g[3:2]));
      chk(32'(split_nibble_qual), 32'(flag_req & ^g[3:2]));
      chk(32'({frame_sync_out, line_sync_out}), 32'(passthru_mode ? sync_req : sync_req ^ g[1:0]));
    end
    d = xs();
    pix <= d[23:0];
    passthru_mode <= 1'b0;
    repeat (8) @(posedge aclk);
    axw(PCT_OFF_TEST, 8'h01, r);
    for (int i = 1; i < 4; i++) begin
      axr(PCT_OFF_TEST, d, r);
      chk(d, chan_val(3'(i % 3)));
    end
    axw(PCT_OFF_TEST, 8'h03, r);
    for (int i = 0; i < 6; i++) begin
      axr(PCT_OFF_TEST, d, r);
      chk(d, chan_val(i == 0 ? 3'h3 : 3'((i - 1) % 3)));
    end
    for (int k = 4; k < 8; k++) begin
      axw(PCT_OFF_TEST, 8'(k), r);
      repeat (2) begin
        axr(PCT_OFF_TEST, d, r);
        chk(d, chan_val(3'(k)));
      end
    end
    axw(PCT_OFF_TEST, 8'h57, r);
    axr(PCT_OFF_TEST, d, r);
    chk(d, 32'h0000_0057);
    chk(32'(r), 32'(PCT_RESP_OKAY));
    axr(32'h0000_0010, d, r);
    chk(32'(r), 32'(PCT_RESP_SLVERR));
    chk(d, 32'h0000_0000);
    axw(PCT_OFF_GCTL, 8'hF3, r);
    axw(32'h0000_0008, 8'h00, r);
    chk(32'(r), 32'(PCT_RESP_SLVERR));
    repeat (8) @(posedge aclk);
    chk(32'(ext_select_out), 32'h0000_0001);
    // mid-run reset: defaults return, channel back to red
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(PCT_OFF_GCTL, d, r);
    chk(d, {24'h0, PCT_GCTL_RESET});
    chk(32'(ext_select_out), 32'h0000_0000);
    s_wstrb <= 4'hE;
    axw(PCT_OFF_GCTL, 8'hF0, r);
    s_wstrb <= 4'hF;
    chk(32'(r), 32'(PCT_RESP_OKAY));
    axr(PCT_OFF_GCTL, d, r);
    chk(d, {24'h0, PCT_GCTL_RESET});
    axr(PCT_OFF_TEST, d, r);
    chk(d, chan_val(3'h0));
    give_verdict();
  end
endmodule
bind pct_regs pct_regs_chk pct_regs_chk_inst (.aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
  .s_rready(s_rready), .s_rdata(s_rdata), .passthru_mode(passthru_mode), .ext_select_out(ext_select_out),
  .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out), .split_transfer_enable(split_transfer_enable),
  .nibble_mode_enable(nibble_mode_enable), .split_nibble_qual(split_nibble_qual));
`default_nettype wire
